//--- rtl/sdcr_pkg.sv
// Package of register map constants for the stereo DAC control register bank
package sdcr_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_POWER_MANAGEMENT = 8'h00;
	localparam logic [7:0] ADDR_CLOCK_SPEED_CONTROL = 8'h01;
	localparam logic [7:0] ADDR_AUDIO_FORMAT_CONTROL = 8'h02;
	localparam logic [7:0] ADDR_MUTE_FILTER_CONTROL = 8'h03;
	localparam logic [7:0] ADDR_LEFT_ATTENUATION = 8'h04;
	localparam logic [7:0] ADDR_RIGHT_ATTENUATION = 8'h05;
	localparam logic [7:0] ADDR_LAST = 8'h05;
	localparam int NUM_REGS = 6;
	// Reset values
	localparam logic [7:0] RST_POWER_MANAGEMENT = 8'h02;
	localparam logic [7:0] RST_CLOCK_SPEED_CONTROL = 8'h00;
	localparam logic [7:0] RST_AUDIO_FORMAT_CONTROL = 8'h06;
	localparam logic [7:0] RST_MUTE_FILTER_CONTROL = 8'h01;
	localparam logic [7:0] RST_ATTENUATION = 8'h18;
	// Writable bit masks; zero positions are fixed zero
	localparam logic [7:0] MASK_POWER_MANAGEMENT = 8'h02;
	localparam logic [7:0] MASK_CLOCK_SPEED_CONTROL = 8'h07;
	localparam logic [7:0] MASK_AUDIO_FORMAT_CONTROL = 8'h7F;
	localparam logic [7:0] MASK_MUTE_FILTER_CONTROL = 8'h1F;
	localparam logic [7:0] MASK_ATTENUATION = 8'hFF;
	// Field positions
	localparam int POS_DAC_POWER_ON = 1;
	localparam int POS_CLOCK_AUTO = 0;
	localparam int POS_SPEED_LO = 1;
	localparam int POS_FORMAT_LO = 0;
	localparam int POS_MULTIPLEX_LO = 3;
	localparam int POS_SLOT_LO = 5;
	localparam int POS_SYNC = 0;
	localparam int POS_MUTE = 1;
	localparam int POS_ATTEN_TRANSITION = 2;
	localparam int POS_SHORT_DELAY = 3;
	localparam int POS_SLOW_ROLLOFF = 4;
	// Speed modes driven out
	localparam logic [1:0] SPEED_AUTO = 2'h3;
	// Filter selections
	typedef enum logic [3:0] {
		SDCR_FILT_SHARP = 4'h1,
		SDCR_FILT_SLOW = 4'h2,
		SDCR_FILT_SD_SHARP = 4'h4,
		SDCR_FILT_SD_SLOW = 4'h8
	} sdcr_filter_t;
endpackage : sdcr_pkg

//--- rtl/sdcr_if.sv
// Interface carrying register writes and reads to the register storage module
`timescale 1ns/1ps
interface sdcr_if;
	logic wr_en; // One-cycle write strobe
	logic [2:0] wr_index; // Register index
	logic [7:0] wr_data; // Unmasked write data; storage applies the mask
	logic [2:0] rd_index; // Read index
	logic [7:0] rd_data; // Registered read data
	logic [7:0] regs [0:5]; // Live register contents
	modport ctrl (output wr_en, wr_index, wr_data, rd_index, input rd_data, regs);
	modport store (input wr_en, wr_index, wr_data, rd_index, output rd_data, regs);
endinterface : sdcr_if

//--- rtl/sdcr_regfile.sv
// Register storage with defaults and registered read port
`timescale 1ns/1ps
module sdcr_regfile (
	input wire logic clk,
	input wire logic rst,
	input wire logic init, // Power-down pin held low
	sdcr_if.store bus
);
	logic [7:0] next_regs [0:5]; // Next register values
	logic [7:0] next_rd_data; // Next read data
	logic [7:0] rst_val [0:5]; // Default per register
	logic [7:0] mask [0:5]; // Writable bits per register

	////////////////////////////////////////////////////////////////////////
	// Constant tables
	assign rst_val[0] = sdcr_pkg::RST_POWER_MANAGEMENT;
	assign rst_val[1] = sdcr_pkg::RST_CLOCK_SPEED_CONTROL;
	assign rst_val[2] = sdcr_pkg::RST_AUDIO_FORMAT_CONTROL;
	assign rst_val[3] = sdcr_pkg::RST_MUTE_FILTER_CONTROL;
	assign rst_val[4] = sdcr_pkg::RST_ATTENUATION;
	assign rst_val[5] = sdcr_pkg::RST_ATTENUATION;
	assign mask[0] = sdcr_pkg::MASK_POWER_MANAGEMENT;
	assign mask[1] = sdcr_pkg::MASK_CLOCK_SPEED_CONTROL;
	assign mask[2] = sdcr_pkg::MASK_AUDIO_FORMAT_CONTROL;
	assign mask[3] = sdcr_pkg::MASK_MUTE_FILTER_CONTROL;
	assign mask[4] = sdcr_pkg::MASK_ATTENUATION;
	assign mask[5] = sdcr_pkg::MASK_ATTENUATION;

	////////////////////////////////////////////////////////////////////////
	// Next state: defaults on init, masked write otherwise
	always_comb begin
		for (int i = 0; i < sdcr_pkg::NUM_REGS; i++) begin
			next_regs[i] = bus.regs[i];
			if (init) begin
				next_regs[i] = rst_val[i];
			end else if (bus.wr_en && (bus.wr_index == 3'(i))) begin
				next_regs[i] = bus.wr_data & mask[i];
			end
		end
		next_rd_data = 8'h00;
		if (bus.rd_index <= 3'h5) begin
			next_rd_data = bus.regs[bus.rd_index] & mask[bus.rd_index];
		end
	end

	// Register stage
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < sdcr_pkg::NUM_REGS; i++) begin
				bus.regs[i] <= rst_val[i];
			end
			bus.rd_data <= 8'h00;
		end else begin
			for (int i = 0; i < sdcr_pkg::NUM_REGS; i++) begin
				bus.regs[i] <= next_regs[i];
			end
			bus.rd_data <= next_rd_data;
		end
	end
endmodule : sdcr_regfile

//--- rtl/sdcr_top.sv
// Control register bank of a two-channel audio DAC
`timescale 1ns/1ps
// Summary of operation
// - Power bit set means DAC runs
// - Auto clock enable ignores speed select
// - Auto clock off: speed field fixes mode
// - Format field resets to 110
// - Multiplex field picks stereo, TDM128, TDM256
// - Slot select resets to normal usage
// - Soft mute bit mutes all outputs
// - Attenuator transition resets to zero
// - Two bits choose interpolation filter
// - Per-channel attenuation, defaults 0x18
// - Power-down pin low restores defaults
// - Address auto-increments, wraps after 05H
// - Writes ignored while power-down low
module sdcr_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic power_down_pin_n, // Active-low power-down pin
	input wire logic addr_load, // Pulse: load start address
	input wire logic [7:0] addr_in, // Start address for a sequence
	input wire logic data_valid, // Pulse: one write data byte
	input wire logic [7:0] data_in, // Write data byte
	input wire logic rd_req, // Pulse: read at current address
	output logic rd_valid, // Pulse: read data ready
	output logic [7:0] rd_data, // Read data byte
	output logic [7:0] cur_addr, // Current address counter
	output logic dac_power_on,
	output logic clock_auto_setting_enable,
	output logic [1:0] speed_select, // Effective speed, 3 means auto
	output logic [2:0] audio_format_select,
	output logic [1:0] multiplex_format_select,
	output logic multiplex_invalid, // TDM256 chosen in normal speed
	output logic [1:0] slot_data_select,
	output logic sync_mode_enable,
	output logic soft_mute_enable,
	output logic attenuator_transition_select,
	output sdcr_pkg::sdcr_filter_t filter_mode,
	output logic [7:0] left_attenuation_level,
	output logic [7:0] right_attenuation_level
);
	sdcr_if rif (); // Storage connection
	logic [7:0] next_cur_addr; // Next address counter
	logic next_rd_valid; // Next read strobe
	logic rd_pend; // Read issued last cycle
	logic [7:0] r0, r1, r2, r3; // Control register copies
	logic init; // Power-down asserted

	////////////////////////////////////////////////////////////////////////
	// Storage
	assign init = !power_down_pin_n;
	sdcr_regfile u_store (
		.clk(clk),
		.rst(rst),
		.init(init),
		.bus(rif.store)
	);

	////////////////////////////////////////////////////////////////////////
	// Address counter and write path
	always_comb begin
		next_cur_addr = cur_addr;
		rif.wr_en = 1'b0;
		rif.wr_index = cur_addr[2:0];
		rif.wr_data = data_in;
		rif.rd_index = cur_addr[2:0];
		next_rd_valid = rd_req && !init;
		if (init) begin
			next_cur_addr = 8'h00;
		end else if (addr_load) begin
			next_cur_addr = addr_in;
		end else if (data_valid) begin
			// Out-of-map address never stores; host must avoid it
			rif.wr_en = (cur_addr <= sdcr_pkg::ADDR_LAST);
			if (cur_addr >= sdcr_pkg::ADDR_LAST) begin
				next_cur_addr = 8'h00;
			end else begin
				next_cur_addr = cur_addr + 8'h01;
			end
		end
	end

	// Counter and read strobe registers
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_addr <= 8'h00;
			rd_pend <= 1'b0;
		end else begin
			cur_addr <= next_cur_addr;
			rd_pend <= next_rd_valid;
		end
	end
	assign rd_valid = rd_pend;
	assign rd_data = rif.rd_data;

	////////////////////////////////////////////////////////////////////////
	// Field decode
	assign r0 = rif.regs[0];
	assign r1 = rif.regs[1];
	assign r2 = rif.regs[2];
	assign r3 = rif.regs[3];
	assign dac_power_on = r0[sdcr_pkg::POS_DAC_POWER_ON];
	assign clock_auto_setting_enable = r1[sdcr_pkg::POS_CLOCK_AUTO];
	// Auto mode hides the manual speed field
	assign speed_select = clock_auto_setting_enable ? sdcr_pkg::SPEED_AUTO
		: r1[sdcr_pkg::POS_SPEED_LO +: 2];
	assign audio_format_select = r2[sdcr_pkg::POS_FORMAT_LO +: 3];
	assign multiplex_format_select = r2[sdcr_pkg::POS_MULTIPLEX_LO +: 2];
	// TDM256 needs double or quad speed
	assign multiplex_invalid = multiplex_format_select[1] && !clock_auto_setting_enable
		&& (speed_select == 2'h0);
	assign slot_data_select = r2[sdcr_pkg::POS_SLOT_LO +: 2];
	assign sync_mode_enable = r3[sdcr_pkg::POS_SYNC];
	assign soft_mute_enable = r3[sdcr_pkg::POS_MUTE];
	assign attenuator_transition_select = r3[sdcr_pkg::POS_ATTEN_TRANSITION];
	assign left_attenuation_level = rif.regs[4];
	assign right_attenuation_level = rif.regs[5];

	// Filter choice from short-delay and slow bits
	always_comb begin
		case ({r3[sdcr_pkg::POS_SHORT_DELAY], r3[sdcr_pkg::POS_SLOW_ROLLOFF]})
			2'h0: filter_mode = sdcr_pkg::SDCR_FILT_SHARP;
			2'h1: filter_mode = sdcr_pkg::SDCR_FILT_SLOW;
			2'h2: filter_mode = sdcr_pkg::SDCR_FILT_SD_SHARP;
			default: filter_mode = sdcr_pkg::SDCR_FILT_SD_SLOW;
		endcase
	end
endmodule : sdcr_top

//--- verification/sdcr_checker.sv
// Assertion checker for the stereo DAC control register bank
`timescale 1ns/1ps
module sdcr_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic power_down_pin_n,
	input wire logic addr_load,
	input wire logic data_valid,
	input wire logic [7:0] data_in,
	input wire logic rd_req,
	input wire logic rd_valid,
	input wire logic [7:0] cur_addr,
	input wire logic clock_auto_setting_enable,
	input wire logic [1:0] speed_select,
	input wire logic [7:0] left_attenuation_level,
	input wire sdcr_pkg::sdcr_filter_t filter_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Accepted data byte at the left level register
	sequence s_wr4;
		data_valid && power_down_pin_n && !addr_load && cur_addr == 8'h04;
	endsequence
	property p_pwrdn;
		!power_down_pin_n |=> left_attenuation_level == 8'h18 && cur_addr == 8'h00;
	endproperty
	a_pwrdn: assert property (p_pwrdn) else $error("power-down left state");
	property p_auto;
		clock_auto_setting_enable |-> speed_select == 2'h3;
	endproperty
	a_auto: assert property (p_auto) else $error("auto clock speed");
	property p_rdv;
		rd_req && power_down_pin_n |=> rd_valid;
	endproperty
	a_rdv: assert property (p_rdv) else $error("read not answered");
	property p_rdq;
		!rd_req |=> !rd_valid;
	endproperty
	a_rdq: assert property (p_rdq) else $error("spurious read valid");
	property p_inc;
		data_valid && power_down_pin_n && !addr_load && cur_addr < 8'h05
			|=> cur_addr == $past(cur_addr) + 8'h01;
	endproperty
	a_inc: assert property (p_inc) else $error("address not advanced");
	property p_wrap;
		data_valid && power_down_pin_n && !addr_load && cur_addr >= 8'h05 |=> cur_addr == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("address not wrapped");
	property p_left;
		s_wr4 |=> left_attenuation_level == $past(data_in);
	endproperty
	a_left: assert property (p_left) else $error("left level not written");
	property p_filt;
		$onehot(filter_mode);
	endproperty
	a_filt: assert property (p_filt) else $error("filter not one-hot");
	// Filter choice moves only after an accepted byte to its register or a power-down
	property p_fhold;
		$changed(filter_mode)
			|-> $past(data_valid && power_down_pin_n && !addr_load && cur_addr == 8'h03)
			|| $past(!power_down_pin_n);
	endproperty
	a_fhold: assert property (p_fhold) else $error("filter changed without write");
endmodule : sdcr_checker
bind sdcr_top sdcr_checker i_chk (.clk(clk), .rst(rst), .power_down_pin_n(power_down_pin_n),
	.addr_load(addr_load), .data_valid(data_valid), .data_in(data_in), .rd_req(rd_req),
	.rd_valid(rd_valid), .cur_addr(cur_addr),
	.clock_auto_setting_enable(clock_auto_setting_enable), .speed_select(speed_select),
	.left_attenuation_level(left_attenuation_level), .filter_mode(filter_mode));

//--- verification/sdcr_host.sv
// Host model driving the register strobe port
`timescale 1ns/1ps
module sdcr_host (
	input wire logic clk,
	output logic addr_load,
	output logic [7:0] addr_in,
	output logic data_valid,
	output logic [7:0] data_in,
	output logic rd_req
);
	initial {addr_load, addr_in, data_valid, data_in, rd_req} = '0;
	// Load start address, never past the last register
	task ld(input logic [7:0] a);
		@(negedge clk) addr_load = 1'h1;
		addr_in = (a > 8'h05) ? 8'h00 : a;
		@(negedge clk) addr_load = 1'h0;
		addr_in = ~addr_in;
	endtask : ld
	// One data byte; released data shows its inverse
	task put(input logic [7:0] d);
		@(negedge clk) data_valid = 1'h1;
		data_in = d;
		@(negedge clk) data_valid = 1'h0;
		data_in = ~d;
	endtask : put
	// Read pulse; answer stands at the following falling edge
	task rd(input logic [7:0] a);
		ld(a);
		@(negedge clk) rd_req = 1'h1;
		@(negedge clk) rd_req = 1'h0;
	endtask : rd
endmodule : sdcr_host

//--- verification/stereo_dac_control_registers_tb.sv
// Self-checking bench for the stereo DAC control register bank
`timescale 1ns/1ps
module stereo_dac_control_registers_tb;
	logic clk, rst, power_down_pin_n; // Clock, reset and power-down pin, set at time zero
	logic addr_load, data_valid, rd_req, rd_valid, dac_power_on, clock_auto_setting_enable;
	logic multiplex_invalid, sync_mode_enable, soft_mute_enable, attenuator_transition_select;
	logic [7:0] addr_in, data_in, rd_data, cur_addr, left_attenuation_level, right_attenuation_level;
	logic [1:0] speed_select, multiplex_format_select, slot_data_select;
	logic [2:0] audio_format_select;
	sdcr_pkg::sdcr_filter_t filter_mode;
	int n_fail = 0, comparisons = 0;
	// Rows of address and data; fixed-zero bits left clear
	logic [15:0] rows [6] = '{16'h0000, 16'h0104, 16'h027F, 16'h031E, 16'h04A5, 16'h055A};
	logic [7:0] defs [6] = '{8'h02, 8'h00, 8'h06, 8'h01, 8'h18, 8'h18};
	always #2 clk = ~clk;
	sdcr_top i_dut (.clk(clk), .rst(rst), .power_down_pin_n(power_down_pin_n),
		.addr_load(addr_load), .addr_in(addr_in), .data_valid(data_valid), .data_in(data_in),
		.rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data), .cur_addr(cur_addr),
		.dac_power_on(dac_power_on), .clock_auto_setting_enable(clock_auto_setting_enable),
		.speed_select(speed_select), .audio_format_select(audio_format_select),
		.multiplex_format_select(multiplex_format_select), .multiplex_invalid(multiplex_invalid),
		.slot_data_select(slot_data_select), .sync_mode_enable(sync_mode_enable),
		.soft_mute_enable(soft_mute_enable),
		.attenuator_transition_select(attenuator_transition_select), .filter_mode(filter_mode),
		.left_attenuation_level(left_attenuation_level),
		.right_attenuation_level(right_attenuation_level));
	sdcr_host i_host (.clk(clk), .addr_load(addr_load), .addr_in(addr_in),
		.data_valid(data_valid), .data_in(data_in), .rd_req(rd_req));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task rchk(input logic [7:0] a, input logic [7:0] e);
		i_host.rd(a);
		chk({7'h0, rd_valid}, 8'h01);
		chk(rd_data, e);
	endtask : rchk
	task report_and_stop;
		$display("fails %0d of %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// Watchdog
	initial begin
		#20000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		clk = 1'h0;
		rst = 1'h1;
		power_down_pin_n = 1'h1;
		repeat (4) @(negedge clk);
		rst = 1'h0;
		for (int i = 0; i < 6; i++) rchk(i[7:0], defs[i]);
		for (int i = 0; i < 6; i++) begin
			i_host.ld(rows[i][15:8]);
			i_host.put(rows[i][7:0]);
			rchk(rows[i][15:8], rows[i][7:0]);
		end
		// Every field after the row writes
		chk({7'h0, dac_power_on}, 8'h00);
		chk({6'h0, speed_select}, 8'h02);
		chk({7'h0, clock_auto_setting_enable}, 8'h00);
		chk({5'h0, audio_format_select}, 8'h07);
		chk({6'h0, multiplex_format_select}, 8'h03);
		chk({7'h0, multiplex_invalid}, 8'h00);
		chk({6'h0, slot_data_select}, 8'h03);
		chk({7'h0, sync_mode_enable}, 8'h00);
		chk({7'h0, soft_mute_enable}, 8'h01);
		chk({7'h0, attenuator_transition_select}, 8'h01);
		chk({4'h0, filter_mode}, 8'h08);
		chk(left_attenuation_level, 8'hA5);
		chk(right_attenuation_level, 8'h5A);
		// Manual normal speed with a 256-slot multiplex is flagged
		i_host.ld(8'h01);
		i_host.put(8'h00);
		chk({6'h0, speed_select}, 8'h00);
		chk({7'h0, multiplex_invalid}, 8'h01);
		i_host.ld(8'h01);
		i_host.put(8'h05);
		chk({6'h0, speed_select}, 8'h03);
		chk({7'h0, clock_auto_setting_enable}, 8'h01);
		chk({7'h0, multiplex_invalid}, 8'h00);
		i_host.ld(8'h05);
		i_host.put(8'h11);
		i_host.put(8'h02);
		chk(cur_addr, 8'h01);
		rchk(8'h05, 8'h11);
		chk({7'h0, dac_power_on}, 8'h01);
		// Power-down: loads, writes and reads are all ignored
		power_down_pin_n = 1'h0;
		i_host.ld(8'h04);
		i_host.put(8'h77);
		chk(cur_addr, 8'h00);
		i_host.rd(8'h03);
		chk({7'h0, rd_valid}, 8'h00);
		power_down_pin_n = 1'h1;
		for (int i = 0; i < 6; i++) rchk(i[7:0], defs[i]);
		report_and_stop();
	end
endmodule : stereo_dac_control_registers_tb
